/* inc/fcs_pkg.sv */
// Package for the flash command sequencer: register map, command codes,
// mode encodings, field layouts and timing counts.
// Assumes a 32-bit APB slave at 10 MHz and a simple flash array port.
package fcs_pkg;

  // Register byte offsets (APB, one aligned word each)
  localparam logic [7:0] OFF_CMD_INDEX   = 8'h00;
  localparam logic [7:0] OFF_CMD_WORD    = 8'h04;
  localparam logic [7:0] OFF_STATUS      = 8'h08;
  localparam logic [7:0] OFF_MODE        = 8'h0C;
  localparam logic [7:0] OFF_PART_SEL    = 8'h10;
  localparam logic [7:0] OFF_ONCE_STATE  = 8'h14;

  // Status register field positions
  localparam int STS_COMMAND_COMPLETE_FLAG_BIT   = 7;
  localparam int STS_ACCESS_ERROR_FLAG_BIT = 5;
  localparam int STS_PROTECTION_VIOLATION_FLAG_BIT = 4;
  localparam int STS_MG1_BIT    = 1;
  localparam int STS_MG0_BIT    = 0;

  // Command codes
  localparam logic [7:0] CMD_ERVFY_ALL   = 8'h01;
  localparam logic [7:0] CMD_ERVFY_BLK   = 8'h02;
  localparam logic [7:0] CMD_ERVFY_PSEC  = 8'h03;
  localparam logic [7:0] CMD_READ_ONCE   = 8'h04;
  localparam logic [7:0] CMD_LOAD_FIELD  = 8'h05;
  localparam logic [7:0] CMD_PROG_P      = 8'h06;
  localparam logic [7:0] CMD_PROG_ONCE   = 8'h07;
  localparam logic [7:0] CMD_ERASE_ALL   = 8'h08;
  localparam logic [7:0] CMD_ERASE_PBLK  = 8'h09;
  localparam logic [7:0] CMD_ERASE_PSEC  = 8'h0A;
  localparam logic [7:0] CMD_UNSECURE    = 8'h0B;
  localparam logic [7:0] CMD_BACKDOOR    = 8'h0C;
  localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
  localparam logic [7:0] CMD_FIELD_MARG  = 8'h0E;
  localparam logic [7:0] CMD_FULL_PART   = 8'h0F;
  localparam logic [7:0] CMD_ERVFY_DSEC  = 8'h10;
  localparam logic [7:0] CMD_PROG_D      = 8'h11;
  localparam logic [7:0] CMD_ERASE_DSEC  = 8'h12;
  localparam logic [7:0] CMD_EEE_ENABLE  = 8'h13;
  localparam logic [7:0] CMD_EEE_DISABLE = 8'h14;
  localparam logic [7:0] CMD_EEE_QUERY   = 8'h15;
  localparam logic [7:0] CMD_PARTITION   = 8'h20;

  // Required final word index per command
  localparam logic [2:0] IDX_ERVFY_DSEC = 3'h2;
  localparam logic [2:0] IDX_PROG_ONCE  = 3'h5;
  localparam logic [2:0] IDX_ERASE_ALL  = 3'h0;

  // Program-once phrase index limit and count
  localparam logic [15:0] ONCE_IDX_MAX  = 16'h0007;
  localparam int          ONCE_PHRASES  = 8;

  // Partition size limits (largest legal selection)
  localparam logic [15:0] DFLASH_PARTITION_SIZE_MAX    = 16'h0080;
  localparam logic [15:0] BUFFER_RAM_PARTITION_SIZE_MAX    = 16'h0010;

  // Reset values
  localparam logic [2:0]  CMD_INDEX_RST = 3'h0;
  localparam logic [1:0]  MODE_RST      = 2'h0;
  localparam logic        SECURE_RST    = 1'b1;

  // Array operation time per step, in ns, and derived cycle count
  localparam int CLK_PERIOD_NS = 100;
  localparam int ARRAY_STEP_NS = 400;
  localparam int ARRAY_STEP_CYC =
    (ARRAY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Chip operating modes
  typedef enum logic [1:0] {
    FCS_MODE_NORMAL_SINGLE_CHIP,
    FCS_MODE_NORMAL_EXPANDED,
    FCS_MODE_SPECIAL_SINGLE_CHIP,
    FCS_MODE_SPECIAL_MODE_FULL
  } fcs_mode_t;

  // Request from sequencer to array driver
  typedef struct packed {
    logic        start;
    logic [7:0]  command_code;
    logic [22:0] address;
    logic [15:0] count;
  } fcs_array_req_t;

  // Verify result returned by the array driver
  typedef struct packed {
    logic done;
    logic any_error;
    logic uncorrectable;
    logic not_erased;
  } fcs_array_rsp_t;

endpackage : fcs_pkg

/* rtl/fcs_mode_check.sv */
// Command permission table by operating mode and security state.
// Assumes mode and security come from registered state on the same clock.
`timescale 1ns/10ps
module fcs_mode_check (
  // Command under test
  input  wire logic [7:0]        command_code,
  // Chip state
  input  wire fcs_pkg::fcs_mode_t mode,
  input  wire logic              secured,
  // Verdict
  output logic                   permitted
);

  logic ns_mode;
  logic special;

  assign ns_mode = (mode == fcs_pkg::FCS_MODE_NORMAL_SINGLE_CHIP);
  assign special = (mode == fcs_pkg::FCS_MODE_SPECIAL_SINGLE_CHIP) ||
                   (mode == fcs_pkg::FCS_MODE_SPECIAL_MODE_FULL);

  // Codes not listed fall to the default and are refused
  always_comb begin
    unique case (command_code)
      fcs_pkg::CMD_ERVFY_ALL, fcs_pkg::CMD_ERVFY_BLK,
      fcs_pkg::CMD_EEE_ENABLE, fcs_pkg::CMD_EEE_DISABLE,
      fcs_pkg::CMD_EEE_QUERY, fcs_pkg::CMD_PARTITION: begin
        permitted = 1'b1;
      end
      fcs_pkg::CMD_ERVFY_PSEC, fcs_pkg::CMD_READ_ONCE,
      fcs_pkg::CMD_LOAD_FIELD, fcs_pkg::CMD_PROG_P,
      fcs_pkg::CMD_PROG_ONCE, fcs_pkg::CMD_ERASE_PBLK,
      fcs_pkg::CMD_ERASE_PSEC, fcs_pkg::CMD_USER_MARGIN,
      fcs_pkg::CMD_ERVFY_DSEC, fcs_pkg::CMD_PROG_D,
      fcs_pkg::CMD_ERASE_DSEC: begin
        permitted = !secured || ns_mode;
      end
      fcs_pkg::CMD_ERASE_ALL, fcs_pkg::CMD_UNSECURE: begin
        permitted = special;
      end
      fcs_pkg::CMD_BACKDOOR: begin
        permitted = ns_mode;
      end
      fcs_pkg::CMD_FIELD_MARG, fcs_pkg::CMD_FULL_PART: begin
        permitted = special && !secured;
      end
      default: begin
        permitted = 1'b0;
      end
    endcase
  end

endmodule : fcs_mode_check

/* rtl/fcs_array_timer.sv */
// Step timer that paces array operations at the array step rate.
// Assumes start is a one-cycle pulse and steps counts whole operations.
`timescale 1ns/10ps
module fcs_array_timer (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control
  input  wire logic        start,
  input  wire logic [15:0] steps,
  // Progress
  output logic             step_tick,
  output logic             busy
);

  localparam logic [7:0] STEP_CYC = 8'(fcs_pkg::ARRAY_STEP_CYC);

  logic [7:0]  div_reg;
  logic [15:0] left_reg;

  // One tick per step; a zero count still runs one step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg   <= 8'h00;
      left_reg  <= 16'h0000;
      busy      <= 1'b0;
      step_tick <= 1'b0;
    end else begin
      step_tick <= 1'b0;
      if (start) begin
        busy     <= 1'b1;
        div_reg  <= STEP_CYC - 8'h01;
        left_reg <= (steps == 16'h0000) ? 16'h0001 : steps;
      end else if (busy) begin
        if (div_reg == 8'h00) begin
          step_tick <= 1'b1;
          div_reg   <= STEP_CYC - 8'h01;
          left_reg  <= left_reg - 16'h0001;
          if (left_reg == 16'h0001) begin
            busy <= 1'b0;
          end
        end else begin
          div_reg <= div_reg - 8'h01;
        end
      end
    end
  end

endmodule : fcs_array_timer

/* rtl/fcs_sequencer.sv */
// Flash command sequencer: APB registers, launch checks, execution.
// Assumes the flash array reports verify results on array_rsp and that
// mode and security inputs come from the pin-level mode logic.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/10ps

module fcs_sequencer (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Chip mode pins (asynchronous)
  input  wire logic [1:0]  mode_pins,
  input  wire logic        secure_pin,
  // Flash array
  input  wire fcs_pkg::fcs_array_rsp_t array_rsp,
  output fcs_pkg::fcs_array_req_t      array_req,
  output logic             pblock0_read_invalid,
  output logic             secured_out
);

  typedef enum logic [1:0] {
    FCS_IDLE, FCS_RUN, FCS_VERIFY
  } fcs_state_t;

  fcs_state_t  state_reg;
  logic [2:0]  command_word_index_reg;
  logic [15:0] command_object_words_reg [0:5];
  logic        command_complete_flag_reg;
  logic        access_error_flag_reg;
  logic        verify_status_upper_reg;
  logic        verify_status_lower_reg;
  logic [15:0] dflash_partition_size_reg;
  logic [15:0] buffer_ram_partition_size_reg;
  logic [fcs_pkg::ONCE_PHRASES-1:0] once_done_reg;
  logic        load_field_active_reg;
  logic [1:0]  mode_meta_reg, mode_sync_reg;
  logic        sec_meta_reg, sec_sync_reg;
  logic        secure_release_reg;
  logic [7:0]  exec_code_reg;
  logic [2:0]  exec_phrase_reg;
  logic        exec_all_ones_reg;

  logic        wr_acc, rd_acc, launch;
  logic        permitted, mode_ok, launch_err;
  logic [7:0]  code;
  logic [15:0] phrase;
  logic        secured;
  logic        tmr_busy;
  fcs_pkg::fcs_mode_t mode;

  // APB access qualifiers; every access completes with no wait
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign code   = command_object_words_reg[0][15:8];
  assign phrase = command_object_words_reg[1];
  assign mode   = fcs_pkg::fcs_mode_t'(mode_sync_reg);
  assign secured = sec_sync_reg && !secure_release_reg;

  // Writing one to the complete flag launches; ignored while busy
  assign launch = wr_acc && (paddr == fcs_pkg::OFF_STATUS) &&
                  pwdata[fcs_pkg::STS_COMMAND_COMPLETE_FLAG_BIT] &&
                  command_complete_flag_reg;

  // Mode pins cross into the bus clock through two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_meta_reg <= fcs_pkg::MODE_RST;
      mode_sync_reg <= fcs_pkg::MODE_RST;
      sec_meta_reg  <= fcs_pkg::SECURE_RST;
      sec_sync_reg  <= fcs_pkg::SECURE_RST;
    end else begin
      mode_meta_reg <= mode_pins;
      mode_sync_reg <= mode_meta_reg;
      sec_meta_reg  <= secure_pin;
      sec_sync_reg  <= sec_meta_reg;
    end
  end

  fcs_mode_check u_mode_check (
    .command_code (code),
    .mode         (mode),
    .secured      (secured),
    .permitted    (mode_ok)
  );

  assign permitted = mode_ok;

  // Launch checks per command; any failure means no execution
  always_comb begin
    launch_err = !permitted;
    unique case (code)
      fcs_pkg::CMD_ERVFY_DSEC: begin
        if (command_word_index_reg != fcs_pkg::IDX_ERVFY_DSEC) begin
          launch_err = 1'b1;
        end
      end
      fcs_pkg::CMD_PROG_ONCE: begin
        if (command_word_index_reg != fcs_pkg::IDX_PROG_ONCE) begin
          launch_err = 1'b1;
        end
        if (load_field_active_reg) begin
          launch_err = 1'b1;
        end
        if (phrase > fcs_pkg::ONCE_IDX_MAX) begin
          launch_err = 1'b1;
        end else if (once_done_reg[phrase[2:0]]) begin
          launch_err = 1'b1;
        end
      end
      fcs_pkg::CMD_ERASE_ALL: begin
        if (command_word_index_reg != fcs_pkg::IDX_ERASE_ALL) begin
          launch_err = 1'b1;
        end
      end
      fcs_pkg::CMD_PARTITION, fcs_pkg::CMD_FULL_PART: begin
        if (dflash_partition_size_reg > fcs_pkg::DFLASH_PARTITION_SIZE_MAX ||
            buffer_ram_partition_size_reg > fcs_pkg::BUFFER_RAM_PARTITION_SIZE_MAX) begin
          launch_err = 1'b1;
        end
      end
      default: begin
        launch_err = launch_err;
      end
    endcase
  end

  // Command word index and command words written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_word_index_reg <= fcs_pkg::CMD_INDEX_RST;
      for (int i = 0; i < 6; i++) begin
        command_object_words_reg[i] <= 16'h0000;
      end
    end else if (wr_acc && command_complete_flag_reg) begin
      // Writes during execution are dropped to protect the running command
      if (paddr == fcs_pkg::OFF_CMD_INDEX) begin
        command_word_index_reg <= pwdata[2:0];
      end else if (paddr == fcs_pkg::OFF_CMD_WORD &&
                   command_word_index_reg < 3'h6) begin
        command_object_words_reg[command_word_index_reg] <=
          pwdata[15:0];
      end
    end
  end

  // Partition size selections
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dflash_partition_size_reg     <= 16'h0000;
      buffer_ram_partition_size_reg <= 16'h0000;
    end else if (wr_acc && paddr == fcs_pkg::OFF_PART_SEL &&
                 command_complete_flag_reg) begin
      dflash_partition_size_reg     <= pwdata[15:0];
      buffer_ram_partition_size_reg <= pwdata[31:16];
    end
  end

  // Sequencer state, complete flag and execution bookkeeping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg                 <= FCS_IDLE;
      command_complete_flag_reg <= 1'b1;
      exec_code_reg             <= 8'h00;
      exec_phrase_reg           <= 3'h0;
      exec_all_ones_reg         <= 1'b0;
    end else begin
      unique case (state_reg)
        FCS_IDLE: begin
          if (launch && !launch_err) begin
            state_reg                 <= FCS_RUN;
            command_complete_flag_reg <= 1'b0;
            exec_code_reg             <= code;
            exec_phrase_reg           <= phrase[2:0];
            exec_all_ones_reg         <=
              (command_object_words_reg[2] == 16'hFFFF) &&
              (command_object_words_reg[3] == 16'hFFFF) &&
              (command_object_words_reg[4] == 16'hFFFF) &&
              (command_object_words_reg[5] == 16'hFFFF);
          end
        end
        FCS_RUN: begin
          if (!tmr_busy && !array_req.start) begin
            state_reg <= FCS_VERIFY;
          end
        end
        FCS_VERIFY: begin
          if (array_rsp.done) begin
            state_reg                 <= FCS_IDLE;
            command_complete_flag_reg <= 1'b1;
          end
        end
        default: begin
          state_reg <= FCS_IDLE;
        end
      endcase
    end
  end

  // Array request; nothing is issued for a refused launch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      array_req <= '0;
    end else begin
      array_req.start <= launch && !launch_err;
      if (launch && !launch_err) begin
        array_req.command_code <= code;
        array_req.address <= {command_object_words_reg[0][6:0],
                              command_object_words_reg[1]};
        array_req.count <= (code == fcs_pkg::CMD_ERVFY_DSEC) ?
          command_object_words_reg[2] : 16'h0001;
      end
    end
  end

  fcs_array_timer u_timer (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (array_req.start),
    .steps     (array_req.count),
    .step_tick (), // Run end is taken from busy, so step pulses go unused
    .busy      (tmr_busy)
  );

  // Error flags; a new event wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_error_flag_reg   <= 1'b0;
      verify_status_upper_reg <= 1'b0;
      verify_status_lower_reg <= 1'b0;
    end else begin
      if (launch) begin
        verify_status_upper_reg <= 1'b0;
        verify_status_lower_reg <= 1'b0;
      end
      if (wr_acc && paddr == fcs_pkg::OFF_STATUS &&
          pwdata[fcs_pkg::STS_ACCESS_ERROR_FLAG_BIT]) begin
        access_error_flag_reg <= 1'b0;
      end
      if (launch && launch_err) begin
        access_error_flag_reg <= 1'b1;
      end
      if (state_reg == FCS_VERIFY && array_rsp.done) begin
        verify_status_upper_reg <= array_rsp.any_error;
        verify_status_lower_reg <= array_rsp.uncorrectable;
      end
    end
  end

  // Phrase bookkeeping, load-field tracking and security release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      once_done_reg         <= '0;
      load_field_active_reg <= 1'b0;
      secure_release_reg    <= 1'b0;
    end else begin
      if (wr_acc && paddr == fcs_pkg::OFF_ONCE_STATE &&
          command_complete_flag_reg) begin
        load_field_active_reg <= pwdata[0];
      end
      if (state_reg == FCS_VERIFY && array_rsp.done) begin
        if (exec_code_reg == fcs_pkg::CMD_PROG_ONCE &&
            !exec_all_ones_reg) begin
          once_done_reg[exec_phrase_reg] <= 1'b1;
        end
        if (exec_code_reg == fcs_pkg::CMD_ERASE_ALL) begin
          once_done_reg <= '0;
          if (!array_rsp.not_erased) begin
            secure_release_reg <= 1'b1;
          end
        end
      end
    end
  end

  // Block 0 reads are poisoned while a program-once executes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pblock0_read_invalid <= 1'b0;
      secured_out          <= 1'b1;
    end else begin
      pblock0_read_invalid <= (state_reg != FCS_IDLE) &&
        (exec_code_reg == fcs_pkg::CMD_PROG_ONCE);
      secured_out <= secured;
    end
  end

  // APB read data registered in setup, answered in access with no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr > fcs_pkg::OFF_ONCE_STATE ||
                 paddr[1:0] != 2'h0);
      if (rd_acc) begin
        unique case (paddr)
          fcs_pkg::OFF_CMD_INDEX:
            prdata <= {29'h0, command_word_index_reg};
          fcs_pkg::OFF_CMD_WORD:
            prdata <= (command_word_index_reg < 3'h6) ?
              {16'h0, command_object_words_reg[command_word_index_reg]} :
              32'h0000_0000;
          fcs_pkg::OFF_STATUS:
            prdata <= {24'h0, command_complete_flag_reg, 1'b0,
                       access_error_flag_reg, 2'h0, 1'b0,
                       verify_status_upper_reg, verify_status_lower_reg};
          fcs_pkg::OFF_MODE:
            prdata <= {29'h0, secured, mode_sync_reg};
          fcs_pkg::OFF_PART_SEL:
            prdata <= {buffer_ram_partition_size_reg,
                       dflash_partition_size_reg};
          fcs_pkg::OFF_ONCE_STATE:
            prdata <= {23'h0, once_done_reg, load_field_active_reg};
          default:
            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // A refused launch raises the error flag on the next edge
  AST_ERR_ON_REFUSE: assert property (@(posedge pclk) disable iff (!presetn)
    launch && launch_err |=> access_error_flag_reg)
    else $error("refused launch did not set access error");

  // A refused launch never reaches the array
  AST_NO_EXEC_ON_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    launch && launch_err |=> !array_req.start)
    else $error("refused launch started the array");

  // Accepted launch clears the complete flag and starts the array
  AST_LAUNCH_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    launch && !launch_err |=> !command_complete_flag_reg && array_req.start)
    else $error("accepted launch did not start");

  // Section verify with wrong index is refused
  AST_DSEC_INDEX: assert property (@(posedge pclk) disable iff (!presetn)
    launch && code == fcs_pkg::CMD_ERVFY_DSEC &&
    command_word_index_reg != fcs_pkg::IDX_ERVFY_DSEC |-> launch_err)
    else $error("section verify index not checked");

  // Program-once index out of range is refused
  AST_ONCE_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    launch && code == fcs_pkg::CMD_PROG_ONCE &&
    phrase > fcs_pkg::ONCE_IDX_MAX |=> access_error_flag_reg)
    else $error("phrase index not checked");

  // Block 0 reads flagged invalid while program-once runs
  AST_BLK0_INVALID: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == FCS_RUN && exec_code_reg == fcs_pkg::CMD_PROG_ONCE
    |=> pblock0_read_invalid)
    else $error("block 0 not poisoned");

  // Complete flag stays low until the verify step reports done
  AST_COMMAND_COMPLETE_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !command_complete_flag_reg && !(state_reg == FCS_VERIFY &&
    array_rsp.done) |=> !command_complete_flag_reg)
    else $error("complete flag rose early");

  // Security is released only by a passing erase-all
  AST_SEC_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(secure_release_reg) |-> $past(exec_code_reg) ==
    fcs_pkg::CMD_ERASE_ALL && !$past(array_rsp.not_erased))
    else $error("security released without erase-all");

endmodule : fcs_sequencer

/* tb/fcs_sequencer_tb_top.sv */
// Self-checking bench for the flash command sequencer.
// Drives APB and the array response itself; no separate partner model.
`timescale 1ns/10ps
module fcs_sequencer_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        secure_pin, inv, sec_o;
  logic [1:0]  mode_pins;
  logic [7:0]  paddr, last_code;
  logic [31:0] pwdata, prdata, r, e;
  int          fail_count, cmp_count, n_start, cyc;
  fcs_pkg::fcs_array_rsp_t rsp;
  fcs_pkg::fcs_array_req_t req;

  fcs_sequencer u_fcs_sequencer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_pins(mode_pins), .secure_pin(secure_pin), .array_rsp(rsp),
    .array_req(req), .pblock0_read_invalid(inv), .secured_out(sec_o));

  // Clock at 100 ns
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Count array starts; a refused command must never reach the array
  always @(posedge pclk) begin
    cyc++;
    if (req.start === 1'b1) begin
      n_start++;
      last_code = req.command_code;
    end
    if (cyc == 40000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [31:0] s, x);
    cmp_count++;
    if (s !== x) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Load all six words, set final index, launch, then finish the run
  task automatic run(input logic [7:0] c, input logic [2:0] ix,
                     input logic [15:0] w1, dat, input logic err,
                     input logic [1:0] mg);
    int s0;
    s0 = n_start;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, fcs_pkg::OFF_CMD_INDEX, 32'(i));
      apb(1'b1, fcs_pkg::OFF_CMD_WORD, i == 0 ? {16'h0, c, 8'h00} :
          i == 1 ? {16'h0, w1} : {16'h0, dat});
    end
    apb(1'b1, fcs_pkg::OFF_CMD_INDEX, {29'h0, ix});
    apb(1'b1, fcs_pkg::OFF_STATUS, 32'h0000_0080);
    apb(1'b0, fcs_pkg::OFF_STATUS, 32'h0);
    chk("access_error", r[5], err);
    if (err) begin
      chk("starts", 32'(n_start), 32'(s0));
      apb(1'b1, fcs_pkg::OFF_STATUS, 32'h0000_0020);
    end else begin
      chk("complete_low", r[7], 0);
      chk("code", last_code, c);
      chk("pblock0_invalid", inv, c == fcs_pkg::CMD_PROG_ONCE);
      // A relaunch while busy must be ignored; no writes during erase-all
      if (c != fcs_pkg::CMD_ERASE_ALL) begin
        apb(1'b1, fcs_pkg::OFF_STATUS, 32'h0000_0080);
      end
      // Done pulses outside verify are ignored, so repeat until complete
      for (int k = 0; k < 500 && r[7] !== 1'b1; k++) begin
        rsp <= {1'b1, mg, 1'b0};
        @(posedge pclk);
        rsp <= '0;
        apb(1'b0, fcs_pkg::OFF_STATUS, 32'h0);
      end
      chk("complete_high", r[7], 1);
      chk("verify_status", r[1:0], mg);
      chk("starts", 32'(n_start), 32'(s0 + 1));
      chk("pblock0_idle", inv, 0);
    end
  endtask : run

  task automatic setmode(input logic [1:0] m, input logic s);
    mode_pins <= m;
    secure_pin <= s;
    repeat (4) @(posedge pclk);
  endtask : setmode

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rsp = '0;
    mode_pins = 2'h0;
    secure_pin = 1'b1;
    fail_count = 0;
    cmp_count = 0;
    n_start = 0;
    cyc = 0;
    last_code = 8'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("secured", sec_o, 1);
    apb(1'b0, fcs_pkg::OFF_MODE, 32'h0);
    chk("mode", r[2:0], 3'h4);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped_err", e, 1);
    chk("unmapped_data", r, 0);
    run(8'h10, 3'h2, 16'h0, 16'h1, 0, 2'h3);
    run(8'h10, 3'h1, 16'h0, 16'h1, 1, 2'h0);
    run(8'h0E, 3'h0, 16'h0, 16'h1, 1, 2'h0);
    setmode(2'h1, 1'b1);
    run(8'h03, 3'h2, 16'h0, 16'h1, 1, 2'h0);
    setmode(2'h1, 1'b0);
    run(8'h0C, 3'h0, 16'h0, 16'h1, 1, 2'h0);
    setmode(2'h0, 1'b0);
    run(8'h07, 3'h5, 16'h7, 16'h1, 0, 2'h2);
    run(8'h07, 3'h5, 16'h7, 16'h1, 1, 2'h0);
    run(8'h07, 3'h4, 16'h2, 16'h1, 1, 2'h0);
    run(8'h07, 3'h5, 16'h8, 16'h1, 1, 2'h0);
    apb(1'b1, fcs_pkg::OFF_ONCE_STATE, 32'h1);
    run(8'h07, 3'h5, 16'h2, 16'h1, 1, 2'h0);
    apb(1'b1, fcs_pkg::OFF_ONCE_STATE, 32'h0);
    run(8'h07, 3'h5, 16'h4, 16'hFFFF, 0, 2'h0);
    run(8'h07, 3'h5, 16'h4, 16'h1, 0, 2'h0);
    run(8'h30, 3'h0, 16'h0, 16'h1, 1, 2'h0);
    // Partition sizes: D-flash one above its limit, then both exactly at the limits
    apb(1'b1, fcs_pkg::OFF_PART_SEL, 32'h0000_0081);
    run(8'h20, 3'h0, 16'h0, 16'h1, 1, 2'h0);
    apb(1'b1, fcs_pkg::OFF_PART_SEL, 32'h0010_0080);
    setmode(2'h1, 1'b1);
    run(8'h20, 3'h0, 16'h0, 16'h1, 0, 2'h1);
    run(8'h08, 3'h0, 16'h0, 16'h1, 1, 2'h0);
    // Erase-all in secured special single chip releases security
    setmode(2'h2, 1'b1);
    run(8'h08, 3'h1, 16'h0, 16'h1, 1, 2'h0);
    run(8'h08, 3'h0, 16'h0, 16'h1, 0, 2'h0);
    chk("secured_after_erase", sec_o, 0);
    apb(1'b0, fcs_pkg::OFF_ONCE_STATE, 32'h0);
    chk("phrases_cleared", r, 0);
    apb(1'b0, fcs_pkg::OFF_MODE, 32'h0);
    chk("mode_released", r[2:0], 3'h2);
    summarize();
  end
endmodule : fcs_sequencer_tb_top
